// ### icu_defines.vh
// Purpose: Shared offsets, field positions, reset values and mode codes of the input capture channel.
// Assumes: Included by its bare name from every design file of the channel.
// Notes: Definitions only.
`ifndef ICU_DEFINES_VH
`define ICU_DEFINES_VH

`define ICU_ADDR_W 8
`define ICU_OFF_CTRL 8'h00
`define ICU_OFF_CHRST 8'h04
`define ICU_OFF_SHADOW 8'h08
`define ICU_OFF_FLT_THR 8'h0c
`define ICU_OFF_CNT 8'h10
`define ICU_OFF_EDGE_COUNTER 8'h14
`define ICU_OFF_CAPA 8'h18
`define ICU_OFF_CAPB 8'h1c
`define ICU_OFF_IRQ_STAT 8'h20
`define ICU_OFF_IRQ_CLR 8'h24
`define ICU_OFF_IRQ_EN 8'h28

`define ICU_CTRL_EN 0
`define ICU_CTRL_MODE_LO 1
`define ICU_CTRL_MODE_HI 3
`define ICU_CTRL_OSM 4
`define ICU_CTRL_ROUTE 5
`define ICU_CTRL_ISL 6
`define ICU_CTRL_CSEL_LO 8
`define ICU_CTRL_CSEL_HI 10
`define ICU_CTRL_FILTER_ENABLE_BIT 12
`define ICU_CTRL_RISE_FM 13
`define ICU_CTRL_FALL_FM 14
`define ICU_CTRL_W 15
`define ICU_CTRL_RESET 15'h0000

`define ICU_MODE_PWM 3'h0
`define ICU_MODE_PIA 3'h1
`define ICU_MODE_IEM 3'h2
`define ICU_MODE_PIM 3'h3
`define ICU_MODE_BCM 3'h4
`define ICU_MODE_GPS 3'h5
`define ICU_MODE_SSM 3'h6

`define ICU_CNT_W 24
`define ICU_CNT_RESET 24'h000000
`define ICU_CNT_ONES 24'hffffff
`define ICU_SSM_INIT_ZERO 24'h000000
`define ICU_SSM_INIT_ONES 24'hffffff
`define ICU_SHADOW_SEL_BIT 22
`define ICU_EDGE_COUNTER_W 16
`define ICU_EDGE_COUNTER_RESET 15'h0000
`define ICU_THR_W 8

`define ICU_IRQ_W 3
`define ICU_IRQ_NEW_VALUE_NOTIFY 0
`define ICU_IRQ_GLITCH 1
`define ICU_IRQ_OVF 2
`define ICU_IRQ_RESET 3'h0

`define ICU_PSC_W 8
`endif

// ### icu_prescaler.v
// Purpose: Prescaled clock enables for the capture channel, one pulse every 2 to the power of the selection.
// Assumes: Single system clock; selection comes from a register on the same clock.
// Notes: Selection 0 gives a pulse on every cycle.
`timescale 1ns/1ns
`include "icu_defines.vh"
module icu_prescaler
(
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire [2:0] i_clk_sel,
   output reg o_tick
);
   reg [`ICU_PSC_W-1:0] div_cnt;
   reg [`ICU_PSC_W-1:0] sel_mask;

   always @*
   begin
      sel_mask = ~({`ICU_PSC_W{1'b1}} << i_clk_sel);
   end

   always @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         div_cnt <= 8'h00;
         o_tick <= 1'b0;
      end
      else
      begin
         div_cnt <= div_cnt + 8'h01;
         o_tick <= ((div_cnt & sel_mask) == sel_mask);
      end
   end
endmodule

// ### icu_filter.v
// Purpose: Input edge filter with immediate or delayed propagation and a glitch event.
// Assumes: The input level is already synchronised to the system clock.
// Notes: Thresholds count system clock cycles.
`timescale 1ns/1ns
`include "icu_defines.vh"
module icu_filter
(
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_level,
   input wire i_enable,
   input wire i_rise_mode,
   input wire i_fall_mode,
   input wire [`ICU_THR_W-1:0] i_rise_thr,
   input wire [`ICU_THR_W-1:0] i_fall_thr,
   output reg o_level,
   output reg o_glitch
);
   reg in_q;
   reg busy;
   reg pend;
   reg pmode;
   reg [`ICU_THR_W-1:0] fcnt;
   reg [`ICU_THR_W-1:0] pthr;
   wire new_mode = i_level ? i_rise_mode : i_fall_mode;
   wire [`ICU_THR_W-1:0] new_thr = i_level ? i_rise_thr : i_fall_thr;

   always @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         in_q <= 1'b0;
         busy <= 1'b0;
         pend <= 1'b0;
         pmode <= 1'b0;
         fcnt <= 8'h00;
         pthr <= 8'h00;
         o_level <= 1'b0;
         o_glitch <= 1'b0;
      end
      else
      begin
         in_q <= i_level;
         if (!i_enable)
         begin
            o_level <= i_level;
            busy <= 1'b0;
            fcnt <= 8'h00;
            o_glitch <= 1'b0;
         end
         else
         begin
            o_glitch <= busy & (i_level != in_q) & (pmode | (i_level != pend));
            if (!busy)
            begin
               if (i_level != o_level)
               begin
                  pend <= i_level;
                  pmode <= new_mode;
                  pthr <= new_thr;
                  fcnt <= 8'h00;
                  if (!new_mode)
                  begin
                     o_level <= i_level;
                     busy <= (new_thr != 8'h00);
                  end
                  else if (new_thr == 8'h00)
                  begin
                     o_level <= i_level;
                  end
                  else
                  begin
                     busy <= 1'b1;
                  end
               end
            end
            else if (!pmode)
            begin
               // Acceptance time: input changes are held off until it runs out.
               fcnt <= fcnt + 8'h01;
               if ((fcnt + 8'h01) >= pthr)
               begin
                  busy <= 1'b0;
               end
            end
            else if (i_level == pend)
            begin
               fcnt <= fcnt + 8'h01;
               if ((fcnt + 8'h01) >= pthr)
               begin
                  o_level <= pend;
                  busy <= 1'b0;
               end
            end
            else
            begin
               busy <= 1'b0;
               fcnt <= 8'h00;
            end
         end
      end
   end
endmodule

// ### icu_channel.v
// Purpose: One input capture channel with counter, edge counter, two capture registers and an APB slave.
// Assumes: APB master on i_clk_sys; the capture input is asynchronous to it.
// Notes: Every APB transfer takes one wait state.
// Function
// - Modes 010, 011, 101 and 110 are edge count, pulse integration, gated sampling and serial shift, cleared or, for serial shift, loaded on re-enable.
// - Re-enabling in edge count, pulse integration or gated sampling resets counter, edge counter bits 15:1 and both captures.
// - An event in the enable cycle is counted, starting from the counter's reset value.
// - In gated sampling an active prescaled clock in the enable cycle counts as an event.
// - A capture in the enable cycle is judged on the values derived from reset.
// - Serial shift re-enable loads the counter from the initial level and shadow bit 22, zero when both are zero.
// - Serial shift ignores an input event in the enable cycle.
// - PWM measurement, alternate pulse integration and bit compression keep normal enable behaviour.
// - Writing 1 to the channel reset bit clears the channel's counter and capture state.
// - In that cycle a prescaled clock edge is not counted and no new value notification is raised.
// - Immediate edge propagation applies for filter mode 0, and filtering only when the filter is enabled.
// - A glitch while the filter threshold is pending gives a one-cycle glitch event.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "icu_defines.vh"
module icu_channel
(
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`ICU_ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   input wire i_capture_in,
   output reg o_glitch_event,
   output reg o_irq
);
   reg sync_a;
   reg sync_b;
   reg [`ICU_CTRL_W-1:0] ctrl;
   reg [`ICU_CNT_W-1:0] shadow;
   reg [2*`ICU_THR_W-1:0] flt_thr;
   reg [`ICU_CNT_W-1:0] main_counter;
   reg [`ICU_EDGE_COUNTER_W-1:1] edge_counter;
   reg [`ICU_CNT_W-1:0] capture_reg_a;
   reg [`ICU_CNT_W-1:0] capture_reg_b;
   reg [`ICU_IRQ_W-1:0] irq_stat;
   reg [`ICU_IRQ_W-1:0] irq_en;
   reg en_q;
   reg lvl_q;
   reg [`ICU_CNT_W-1:0] next_cnt;
   reg [`ICU_EDGE_COUNTER_W-1:1] next_edge_counter;
   reg [`ICU_CNT_W-1:0] next_capa;
   reg [`ICU_CNT_W-1:0] next_capb;
   reg [`ICU_IRQ_W-1:0] next_stat;
   reg set_new_value_notify;
   reg set_ovf;
   reg hw_disable;
   reg [31:0] rdata;
   reg rd_err;
   wire flt_level;
   wire flt_glitch;
   wire tick;
   wire channel_enable_bit = ctrl[`ICU_CTRL_EN];
   wire [2:0] channel_mode_field = ctrl[`ICU_CTRL_MODE_HI:`ICU_CTRL_MODE_LO];
   wire one_shot_select = ctrl[`ICU_CTRL_OSM];
   wire initial_signal_level = ctrl[`ICU_CTRL_ISL];
   wire [2:0] prescaled_clock_source = ctrl[`ICU_CTRL_CSEL_HI:`ICU_CTRL_CSEL_LO];
   wire filter_enable_bit = ctrl[`ICU_CTRL_FILTER_ENABLE_BIT];
   wire rise_filter_mode = ctrl[`ICU_CTRL_RISE_FM];
   wire fall_filter_mode = ctrl[`ICU_CTRL_FALL_FM];
   wire en_rise = channel_enable_bit & ~en_q;
   wire edge_rise = flt_level & ~lvl_q;
   wire edge_fall = ~flt_level & lvl_q;
   wire edge_any = edge_rise | edge_fall;
   wire apb_done = i_psel & i_penable & o_pready;
   wire apb_wr = apb_done & i_pwrite;
   wire channel_reset_bit = apb_wr & (i_paddr == `ICU_OFF_CHRST) & i_pwdata[0];
   wire [`ICU_IRQ_W-1:0] irq_clr = (apb_wr & (i_paddr == `ICU_OFF_IRQ_CLR)) ? i_pwdata[`ICU_IRQ_W-1:0] : 3'h0;

   // Modes whose counter and captures restart from reset values on enable.
   function is_clear_mode;
      input [2:0] mode;
      begin
         is_clear_mode = (mode == `ICU_MODE_IEM) | (mode == `ICU_MODE_PIM) | (mode == `ICU_MODE_GPS);
      end
   endfunction

   function [`ICU_CNT_W-1:0] inc24;
      input [`ICU_CNT_W-1:0] value;
      begin
         inc24 = value + 24'h000001;
      end
   endfunction

   icu_prescaler u_prescaler
   (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_clk_sel(prescaled_clock_source),
      .o_tick(tick)
   );

   icu_filter u_filter
   (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_level(sync_b),
      .i_enable(filter_enable_bit),
      .i_rise_mode(rise_filter_mode),
      .i_fall_mode(fall_filter_mode),
      .i_rise_thr(flt_thr[`ICU_THR_W-1:0]),
      .i_fall_thr(flt_thr[2*`ICU_THR_W-1:`ICU_THR_W]),
      .o_level(flt_level),
      .o_glitch(flt_glitch)
   );

   always @*
   begin
      next_cnt = main_counter;
      next_edge_counter = edge_counter;
      next_capa = capture_reg_a;
      next_capb = capture_reg_b;
      set_new_value_notify = 1'b0;
      set_ovf = 1'b0;
      hw_disable = 1'b0;
      if (channel_reset_bit)
      begin
         next_cnt = `ICU_CNT_RESET;
         next_edge_counter = `ICU_EDGE_COUNTER_RESET;
         next_capa = `ICU_CNT_RESET;
         next_capb = `ICU_CNT_RESET;
      end
      else if (channel_enable_bit)
      begin
         // Clear on re-enable.
         // Modes outside the set fall through; serial shift is loaded below, the others keep normal enable.
         if (en_rise & is_clear_mode(channel_mode_field))
         begin
            next_cnt = `ICU_CNT_RESET;
            next_edge_counter = `ICU_EDGE_COUNTER_RESET;
            next_capa = `ICU_CNT_RESET;
            next_capb = `ICU_CNT_RESET;
         end
         if (en_rise & (channel_mode_field == `ICU_MODE_SSM))
         begin
            next_edge_counter = `ICU_EDGE_COUNTER_RESET;
            if (initial_signal_level | shadow[`ICU_SHADOW_SEL_BIT])
            begin
               next_cnt = `ICU_SSM_INIT_ONES;
            end
            else
            begin
               next_cnt = `ICU_SSM_INIT_ZERO;
            end
         end
         // Serial shift drops the enable-cycle event.
         if (edge_any & ~(en_rise & (channel_mode_field == `ICU_MODE_SSM)))
         begin
            next_edge_counter = next_edge_counter + 15'h0001;
         end
         // Events act on the values derived above.
         case (channel_mode_field)
            `ICU_MODE_PWM:
            begin
               if (tick)
               begin
                  set_ovf = (next_cnt == `ICU_CNT_ONES);
                  next_cnt = inc24(next_cnt);
               end
               if (edge_rise)
               begin
                  next_capb = next_capa;
                  next_capa = next_cnt;
                  next_cnt = `ICU_CNT_RESET;
                  set_new_value_notify = 1'b1;
               end
            end
            `ICU_MODE_PIA, `ICU_MODE_PIM:
            begin
               if (tick & flt_level)
               begin
                  set_ovf = (next_cnt == `ICU_CNT_ONES);
                  next_cnt = inc24(next_cnt);
               end
               if (edge_fall)
               begin
                  next_capb = next_capa;
                  next_capa = next_cnt;
                  set_new_value_notify = 1'b1;
               end
            end
            `ICU_MODE_IEM:
            begin
               if (edge_any)
               begin
                  set_ovf = (next_cnt == `ICU_CNT_ONES);
                  next_cnt = inc24(next_cnt);
                  next_capb = next_capa;
                  next_capa = next_cnt;
                  set_new_value_notify = 1'b1;
               end
            end
            `ICU_MODE_GPS:
            begin
               // Prescaled clock counts as the event.
               if (tick)
               begin
                  next_cnt = inc24(next_cnt);
                  if (next_cnt >= shadow)
                  begin
                     next_capa = {8'h00, next_edge_counter, flt_level};
                     next_capb = next_cnt;
                     next_cnt = `ICU_CNT_RESET;
                     set_new_value_notify = 1'b1;
                     hw_disable = one_shot_select;
                  end
               end
            end
            `ICU_MODE_SSM:
            begin
               if (edge_any & ~en_rise)
               begin
                  next_cnt = {next_cnt[`ICU_CNT_W-2:0], flt_level};
                  set_new_value_notify = 1'b1;
               end
            end
            default:
            begin
               next_cnt = next_cnt;
            end
         endcase
      end
   end

   always @*
   begin
      rdata = 32'h00000000;
      rd_err = 1'b0;
      case (i_paddr)
         `ICU_OFF_CTRL: rdata = {17'h00000, ctrl};
         `ICU_OFF_CHRST: rdata = 32'h00000000;
         `ICU_OFF_SHADOW: rdata = {8'h00, shadow};
         `ICU_OFF_FLT_THR: rdata = {16'h0000, flt_thr};
         `ICU_OFF_CNT: rdata = {8'h00, main_counter};
         `ICU_OFF_EDGE_COUNTER: rdata = {16'h0000, edge_counter, flt_level};
         `ICU_OFF_CAPA: rdata = {8'h00, capture_reg_a};
         `ICU_OFF_CAPB: rdata = {8'h00, capture_reg_b};
         `ICU_OFF_IRQ_STAT: rdata = {29'h00000000, irq_stat};
         `ICU_OFF_IRQ_CLR: rdata = 32'h00000000;
         `ICU_OFF_IRQ_EN: rdata = {29'h00000000, irq_en};
         default: rd_err = 1'b1;
      endcase
   end

   always @*
   begin
      // Set wins over clear so an event in the clearing cycle is kept.
      next_stat = (irq_stat & ~irq_clr) | {set_ovf, flt_glitch, set_new_value_notify};
   end

   // The first stage is read only by the second; nothing else looks at it.
   always @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end
      else
      begin
         sync_a <= i_capture_in;
         sync_b <= sync_a;
      end
   end

   always @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end
      else
      begin
         o_pready <= i_psel & i_penable & ~o_pready;
         o_pslverr <= i_psel & i_penable & ~o_pready & rd_err;
         if (i_psel & i_penable & ~o_pready & ~i_pwrite)
         begin
            o_prdata <= rdata;
         end
      end
   end

   always @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ctrl <= `ICU_CTRL_RESET;
         shadow <= `ICU_CNT_RESET;
         flt_thr <= 16'h0000;
         irq_en <= `ICU_IRQ_RESET;
      end
      else
      begin
         if (apb_wr & (i_paddr == `ICU_OFF_CTRL))
         begin
            ctrl <= i_pwdata[`ICU_CTRL_W-1:0];
         end
         else if (hw_disable)
         begin
            ctrl[`ICU_CTRL_EN] <= 1'b0;
         end
         if (apb_wr & (i_paddr == `ICU_OFF_SHADOW))
         begin
            shadow <= i_pwdata[`ICU_CNT_W-1:0];
         end
         if (apb_wr & (i_paddr == `ICU_OFF_FLT_THR))
         begin
            flt_thr <= i_pwdata[2*`ICU_THR_W-1:0];
         end
         if (apb_wr & (i_paddr == `ICU_OFF_IRQ_EN))
         begin
            irq_en <= i_pwdata[`ICU_IRQ_W-1:0];
         end
      end
   end

   always @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         main_counter <= `ICU_CNT_RESET;
         edge_counter <= `ICU_EDGE_COUNTER_RESET;
         capture_reg_a <= `ICU_CNT_RESET;
         capture_reg_b <= `ICU_CNT_RESET;
         irq_stat <= `ICU_IRQ_RESET;
         en_q <= 1'b0;
         lvl_q <= 1'b0;
         o_glitch_event <= 1'b0;
         o_irq <= 1'b0;
      end
      else
      begin
         main_counter <= next_cnt;
         edge_counter <= next_edge_counter;
         capture_reg_a <= next_capa;
         capture_reg_b <= next_capb;
         irq_stat <= next_stat;
         en_q <= channel_enable_bit;
         lvl_q <= flt_level;
         o_glitch_event <= flt_glitch;
         o_irq <= |(next_stat & irq_en);
      end
   end
endmodule

// ### icu_channel_chk.sv
// Purpose: Port-level assertions for the input capture channel.
// Assumes: One clock domain; bound to every instance of icu_channel.
// Notes: Bus checks follow the one-wait-state slave of the channel.
`timescale 1ns/1ns
`include "icu_defines.vh"
module icu_channel_chk
(
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`ICU_ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   input wire i_capture_in,
   input wire o_glitch_event,
   input wire o_irq
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);
   AST_READY_PULSE: assert property (o_pready |=> !o_pready)
      else $error("ready held longer than one cycle");
   AST_READY_WAIT: assert property (i_psel && $rose(i_penable) |=> o_pready)
      else $error("ready not given after one wait state");
   AST_READY_IN_ACCESS: assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside an access phase");
   AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
      else $error("error response without ready");
   AST_ERR_READ_ZERO: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
      else $error("refused read returned data");
   AST_MAPPED_NO_ERR: assert property (o_pready && i_paddr <= `ICU_OFF_IRQ_EN && i_paddr[1:0] == 2'b00 |-> !o_pslverr)
      else $error("mapped register refused");
   AST_CHRST_READS_ZERO: assert property (o_pready && !i_pwrite && i_paddr == `ICU_OFF_CHRST |-> o_prdata == 32'h0)
      else $error("channel reset register read nonzero");
   // Status only drops through a clear or enable write, never by itself.
   AST_IRQ_FALL_BY_WRITE: assert property ($fell(o_irq) |-> $past(i_pwrite && o_pready) || $past(i_pwrite && o_pready, 2))
      else $error("interrupt dropped without a write");
   AST_GLITCH_PULSE: assert property (o_glitch_event |=> !o_glitch_event)
      else $error("glitch event longer than one cycle");
   COV_WRITE: cover property (o_pready && i_pwrite);
   COV_REFUSED: cover property (o_pslverr);
   COV_IRQ: cover property ($rose(o_irq));
   COV_GLITCH: cover property (o_glitch_event);
endmodule
bind icu_channel icu_channel_chk chk_u
(
   .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_capture_in(i_capture_in),
   .o_glitch_event(o_glitch_event), .o_irq(o_irq)
);

// ### icu_sig_src.sv
// Purpose: Outside signal source that drives the channel's capture pin.
// Assumes: Commands come from the bench on the system clock.
// Notes: A pulse inverts the pin for PULSE_LEN cycles; one cycle would still give a single glitch.
`timescale 1ns/1ns
module icu_sig_src
#(
   parameter [3:0] PULSE_LEN = 4'h2
)
(
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_level,
   input wire i_pulse,
   output reg o_pin
);
   reg [3:0] left;
   always @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pin <= 1'b0;
         left <= 4'h0;
      end
      else if (i_pulse && left == 4'h0)
      begin
         o_pin <= ~i_level;
         left <= PULSE_LEN;
      end
      else if (left > 4'h1)
         left <= left - 4'h1;
      else
      begin
         o_pin <= i_level;
         left <= 4'h0;
      end
   end
endmodule

// ### test_input_capture_channel_enable.sv
// Purpose: Self-checking bench for the input capture channel.
// Assumes: APB master on the 20 MHz clock; pin driven by icu_sig_src.
// Notes: Reads queue their expectation; a monitor compares at the ready edge.
`timescale 1ns/1ns
`include "icu_defines.vh"
module test_input_capture_channel_enable;
   // Edges between the effects of two consecutive writes of the apb task.
   localparam integer WR_GAP = 4;
   localparam [47:0] ROWS = {6'h10, 6'h35, 6'h18, 6'h21, 6'h09, 6'h33, 6'h30, 6'h35};
   reg clk_sys = 1'b0;
   reg reset_n = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin_level = 1'b0, pin_pulse = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg [31:0] rnd;
   reg [5:0] row;
   reg [32:0] expq[$];
   wire [31:0] prdata;
   wire pready, pslverr, capture_pin, glitch, irq;
   integer n_errors = 0, checks = 0, n_glitch = 0, i;
   icu_channel dut_u (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_capture_in(capture_pin), .o_glitch_event(glitch), .o_irq(irq));
   icu_sig_src src_u (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_level(pin_level), .i_pulse(pin_pulse),
      .o_pin(capture_pin));
   initial
   begin
      forever #25 clk_sys = ~clk_sys;
   end
   task check(input [32:0] seen, input [32:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp)
         begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("errors %0d, checks %0d", n_errors, checks);
         if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // The request stays put until ready is seen at a rising edge.
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge clk_sys);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         @(posedge clk_sys);
         while (pready !== 1'b1 && n < 40)
         begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (n == 40)
            check(33'h0, 33'h1);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input [7:0] a, input [32:0] e);
      begin
         expq.push_back(e);
         apb(1'b0, a, 32'h0);
      end
   endtask
   // Gated sampling on every clock for exactly WR_GAP edges.
   task run(input [31:0] shadow);
      begin
         wr(`ICU_OFF_SHADOW, shadow);
         wr(`ICU_OFF_CTRL, 32'h0b);
         wr(`ICU_OFF_CTRL, 32'h0a);
      end
   endtask
   task pin_glitch;
      begin
         @(posedge clk_sys);
         pin_level <= 1'b1;
         repeat (2) @(posedge clk_sys);
         pin_pulse <= 1'b1;
         @(posedge clk_sys);
         pin_pulse <= 1'b0;
         repeat (20) @(posedge clk_sys);
      end
   endtask
   always @(posedge clk_sys)
   begin
      if (psel && penable && !pwrite && pready === 1'b1)
      begin
         if (expq.size() == 0)
            expq.push_back(33'hx);
         check({pslverr, prdata}, expq.pop_front());
      end
      if (glitch === 1'b1)
         n_glitch = n_glitch + 1;
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      check(33'h0, 33'h1);
      results;
   end
   initial
   begin
      rnd = $urandom(32'hc2fc);
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (i = 0; i < 11; i = i + 1)
         if (i != 9)
            rd(8'(4 * i), 33'h0);
      rd(8'h2c + 8'(4 * ($urandom % 20)), {1'b1, 32'h0});
      rnd = $urandom;
      wr(`ICU_OFF_SHADOW, rnd);
      rd(`ICU_OFF_SHADOW, {9'h0, rnd[23:0]});
      wr(`ICU_OFF_CNT, rnd);
      rd(`ICU_OFF_CNT, 33'h0);
      run(32'h2);
      rd(`ICU_OFF_IRQ_STAT, 33'h1);
      for (i = 0; i < 2; i = i + 1)
      begin
         run(32'h800000 | ($urandom & 32'hffff));
         rd(`ICU_OFF_CNT, WR_GAP);
         rd(`ICU_OFF_CAPB, 33'h0);
      end
      repeat (20) @(posedge clk_sys);
      rd(`ICU_OFF_CNT, WR_GAP);
      wr(`ICU_OFF_CTRL, 32'h1);
      rd(`ICU_OFF_CNT, WR_GAP + 2);
      wr(`ICU_OFF_CTRL, 32'h0);
      wr(`ICU_OFF_IRQ_CLR, 32'h7);
      wr(`ICU_OFF_IRQ_EN, 32'h1);
      wr(`ICU_OFF_SHADOW, 32'h0);
      wr(`ICU_OFF_CTRL, 32'h5b);
      i = 0;
      while (irq !== 1'b1 && i < 50)
      begin
         @(posedge clk_sys);
         i = i + 1;
      end
      check(irq, 1'b1);
      rd(`ICU_OFF_CTRL, 33'h5a);
      rd(`ICU_OFF_CNT, 33'h0);
      wr(`ICU_OFF_IRQ_CLR, 32'h1);
      rd(`ICU_OFF_IRQ_STAT, 33'h0);
      check(irq, 1'b0);
      run(32'h2);
      wr(`ICU_OFF_CHRST, 32'h1);
      rd(`ICU_OFF_CNT, 33'h0);
      rd(`ICU_OFF_CAPB, 33'h0);
      for (i = 0; i < 8; i = i + 1)
      begin
         row = ROWS[6 * i +: 6];
         wr(`ICU_OFF_SHADOW, {9'h0, row[1], 22'h0});
         wr(`ICU_OFF_CTRL, {25'h0, row[2], 2'b00, row[5:3], 1'b1});
         rd(`ICU_OFF_CNT, {9'h0, {24{row[0]}}});
         wr(`ICU_OFF_CTRL, {28'h0, row[5:3], 1'b0});
      end
      // Pin edge lands in the serial shift enable cycle.
      @(posedge clk_sys);
      pin_level <= 1'b1;
      wr(`ICU_OFF_CTRL, 32'h0d);
      rd(`ICU_OFF_CNT, 33'h0);
      rd(`ICU_OFF_EDGE_COUNTER, 33'h1);
      wr(`ICU_OFF_CTRL, 32'h0c);
      wr(`ICU_OFF_IRQ_CLR, 32'h7);
      rnd = 6 + ($urandom % 8);
      wr(`ICU_OFF_FLT_THR, {16'h0, rnd[7:0], rnd[7:0]});
      wr(`ICU_OFF_CTRL, 32'h1009);
      pin_glitch;
      check(n_glitch != 0, 1'b1);
      check(irq, 1'b0);
      rd(`ICU_OFF_IRQ_STAT, 33'h2);
      wr(`ICU_OFF_IRQ_EN, 32'h2);
      repeat (3) @(posedge clk_sys);
      check(irq, 1'b1);
      wr(`ICU_OFF_IRQ_CLR, 32'h2);
      rd(`ICU_OFF_IRQ_STAT, 33'h0);
      check(irq, 1'b0);
      i = n_glitch;
      wr(`ICU_OFF_CTRL, 32'h0009);
      pin_glitch;
      check(n_glitch, i);
      rd(`ICU_OFF_IRQ_STAT, 33'h0);
      results;
   end
endmodule
